//--- hdl/serial_word_pkg.sv
// Purpose: shared constants for the serial word write port
// Assumes: 16-bit words, msb first
// Notes: field positions of the received command word
`default_nettype none
package serial_word_pkg;
   localparam int WORD_BITS = 16;
   localparam int CTRL_MSB = 15;
   localparam int CTRL_LSB = 12;
   localparam int ADDR_MSB = 11;
   localparam int ADDR_LSB = 8;
   localparam int DATA_MSB = 7;
   localparam int DATA_LSB = 0;
   localparam int SYNC_STAGES = 2;
   localparam logic [15:0] WORD_RESET = 16'h0000;
   localparam logic [4:0] COUNT_RESET = 5'h00;
endpackage
`default_nettype wire

//--- hdl/serial_word_write_port.sv
// Purpose: write-only three-wire serial input port of a waveform generator
// Assumes: shift clock well below MCLK/2; pins synchronised to MCLK
// Notes: link clock edges are found by sampling, not used as a clock
//
// Operation
// - data is sampled at each falling shift clock edge while the frame select is low.
// - each run of sixteen bits inside a frame forms one word; a frame may carry several words.
// - bits travel most significant first.
// - top four bits are control, next four the address, low eight the data.
`default_nettype none
module serial_word_write_port (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // serial link pins
   input wire logic SCLK,
   input wire logic SERIAL_DATA_IN,
   input wire logic FRAME_SELECT_N,
   // received word
   output logic WORD_VALID,
   output logic [15:0] WORD,
   output logic [3:0] WORD_CTRL,
   output logic [3:0] WORD_ADDR,
   output logic [7:0] WORD_DATA,
   output logic FRAME_ERROR
);
   // pin bank order: shift clock, data, frame select; reset to the idle levels
   localparam int PIN_COUNT = 3;
   localparam logic [2:0] PIN_IDLE = 3'h5;
   wire logic [2:0] pin_raw;
   wire logic [2:0] pin_sync;
   logic sclk_prev;
   logic fs_prev;
   logic active;
   logic [4:0] edges;
   logic frame_error;
   word_if word_bus ();

   assign pin_raw = {SCLK, SERIAL_DATA_IN, FRAME_SELECT_N};

   for (genvar p = 0; p < PIN_COUNT; p++) begin : g_sync
      logic [serial_word_pkg::SYNC_STAGES-1:0] stage;
      always_ff @(posedge MCLK) begin
         if (RST) begin
            stage <= {serial_word_pkg::SYNC_STAGES{PIN_IDLE[p]}};
         end else begin
            stage <= {stage[serial_word_pkg::SYNC_STAGES-2:0], pin_raw[p]};
         end
      end
      // only the last stage leaves the bank, so no logic sees a metastable bit
      assign pin_sync[p] = stage[serial_word_pkg::SYNC_STAGES-1];
   end

   always_ff @(posedge MCLK) begin
      if (RST) begin
         sclk_prev <= 1'b1;
         fs_prev <= 1'b1;
      end else begin
         sclk_prev <= pin_sync[2];
         fs_prev <= pin_sync[0];
      end
   end

   // sync delay is equal on all pins, so relative timing is kept
   wire frame_low = !pin_sync[0];
   wire sclk_fall = sclk_prev && !pin_sync[2];
   wire bit_strobe = sclk_fall && frame_low && active;
   wire fs_rise = !fs_prev && pin_sync[0];
   // a frame ending after a partial word drops it
   wire short_frame = fs_rise && (edges != 5'h00);

   always_ff @(posedge MCLK) begin
      if (RST) begin
         active <= 1'b0;
         edges <= 5'h00;
         frame_error <= 1'b0;
      end else begin
         active <= frame_low;
         if (fs_rise || !frame_low) begin
            edges <= 5'h00;
         end else if (bit_strobe) begin
            edges <= (edges == 5'(serial_word_pkg::WORD_BITS - 1)) ? 5'h00 : edges + 5'h01;
         end
         frame_error <= short_frame;
      end
   end

   word_shifter #(
      .WIDTH(serial_word_pkg::WORD_BITS)
   ) u_shifter (
      .clk(MCLK),
      .rst(RST),
      .bit_strobe(bit_strobe),
      .bit_value(pin_sync[1]),
      .frame_abort(short_frame || !frame_low),
      .out(word_bus.source)
   );

   assign WORD_VALID = word_bus.valid;
   assign WORD = word_bus.word;
   assign WORD_CTRL = word_bus.ctrl;
   assign WORD_ADDR = word_bus.addr;
   assign WORD_DATA = word_bus.data;
   assign FRAME_ERROR = frame_error;
endmodule
`default_nettype wire

//--- hdl/word_if.sv
// Purpose: carries a decoded word from the shifter to the top
// Assumes: single clock domain
// Notes: valid is a one-cycle pulse
`default_nettype none
interface word_if;
   logic valid;
   logic [3:0] ctrl;
   logic [3:0] addr;
   logic [7:0] data;
   logic [15:0] word;
   modport source (output valid, output ctrl, output addr, output data, output word);
   modport sink (input valid, input ctrl, input addr, input data, input word);
endinterface
`default_nettype wire

//--- hdl/word_shifter.sv
// Purpose: shifts sampled bits into a word and decodes the fields
// Assumes: bit_strobe marks a falling shift clock edge inside a frame
// Notes: frame_abort drops a partial word
`default_nettype none
module word_shifter #(
   parameter int WIDTH = serial_word_pkg::WORD_BITS
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // sampled link events
   input wire logic bit_strobe,
   input wire logic bit_value,
   input wire logic frame_abort,
   // decoded word
   word_if.source out
);
   logic [WIDTH-1:0] shift;
   logic [4:0] count;
   logic [WIDTH-1:0] next_shift;
   wire last_bit = bit_strobe && (count == 5'(WIDTH - 1));

   // msb arrives first, so shift toward the top
   assign next_shift = {shift[WIDTH-2:0], bit_value};

   always_ff @(posedge clk) begin
      if (rst || frame_abort) begin
         count <= serial_word_pkg::COUNT_RESET;
      end else if (last_bit) begin
         count <= serial_word_pkg::COUNT_RESET;
      end else if (bit_strobe) begin
         count <= count + 5'h01;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         shift <= serial_word_pkg::WORD_RESET;
      end else if (bit_strobe) begin
         shift <= next_shift;
      end
   end

   always_ff @(posedge clk) begin
      if (rst) begin
         out.valid <= 1'b0;
         out.word <= serial_word_pkg::WORD_RESET;
         out.ctrl <= 4'h0;
         out.addr <= 4'h0;
         out.data <= 8'h00;
      end else begin
         out.valid <= last_bit && !frame_abort;
         if (last_bit && !frame_abort) begin
            out.word <= next_shift;
            out.ctrl <= next_shift[serial_word_pkg::CTRL_MSB:serial_word_pkg::CTRL_LSB];
            out.addr <= next_shift[serial_word_pkg::ADDR_MSB:serial_word_pkg::ADDR_LSB];
            out.data <= next_shift[serial_word_pkg::DATA_MSB:serial_word_pkg::DATA_LSB];
         end
      end
   end
endmodule
`default_nettype wire

//--- tb/serial_host_model.sv
// Purpose: host side of the serial link
// Assumes: shift clock half period 160 ns
// Notes: clock idles high between frames
`default_nettype none
module serial_host_model (
   // link pins
   output logic sclk,
   output logic sdi,
   output logic sel_n
);
   timeunit 1ns;
   timeprecision 1ns;
   initial sclk = 1'b1;
   initial sdi = 1'b0;
   initial sel_n = 1'b1;
   task automatic send(input logic [15:0] w, input int n, input bit split);
      sel_n = 1'b0;
      #160;
      for (int i = 15; i > 15 - n; i--) begin
         sdi = w[i];
         #160 sclk = 1'b0;
         #160 sclk = 1'b1;
         if (split && i == 8) #640;
      end
      #160 sel_n = 1'b1;
      // released line: never leave the last bit showing
      sdi = ~sdi;
      #320;
   endtask
endmodule
`default_nettype wire

//--- tb/serial_word_write_port_checker.sv
// Purpose: output assertions of the word port
// Assumes: bound to the top module
// Notes: idle window outlasts the pin synchronisers
`default_nettype none
module serial_word_write_port_checker (
   // clock and reset
   input wire logic MCLK,
   input wire logic RST,
   // watched ports
   input wire logic FRAME_SELECT_N,
   input wire logic WORD_VALID,
   input wire logic [15:0] WORD,
   input wire logic [3:0] WORD_CTRL,
   input wire logic [3:0] WORD_ADDR,
   input wire logic [7:0] WORD_DATA,
   input wire logic FRAME_ERROR
);
   default clocking @(posedge MCLK); endclocking
   default disable iff (RST);
   sequence idle_s;
      FRAME_SELECT_N [*8];
   endsequence
   chk_idle_quiet: assert property (idle_s |-> !WORD_VALID && !FRAME_ERROR)
      else $error("pulse while deselected");
   chk_valid_single: assert property (WORD_VALID |=> !WORD_VALID [*3])
      else $error("word pulse too long");
   chk_data_field: assert property (WORD_VALID |-> WORD_DATA == WORD[7:0])
      else $error("data field wrong");
   chk_ctrl_field: assert property (WORD_VALID |-> WORD_CTRL == WORD[15:12])
      else $error("control field wrong");
   chk_addr_field: assert property (WORD_VALID |-> WORD_ADDR == WORD[11:8])
      else $error("address field wrong");
   // pin edge reaches the outputs three samples later through the synchronisers
   chk_valid_in_frame: assert property (WORD_VALID |-> !$past(FRAME_SELECT_N, 3))
      else $error("word outside a frame");
   chk_error_after_end: assert property (FRAME_ERROR |-> $past(FRAME_SELECT_N, 3))
      else $error("error while selected");
   chk_word_holds: assert property (!WORD_VALID |-> $stable(WORD))
      else $error("word changed unannounced");
   chk_error_alone: assert property (FRAME_ERROR |-> !WORD_VALID ##1 !FRAME_ERROR)
      else $error("error pulse wrong");
endmodule
bind serial_word_write_port serial_word_write_port_checker i_chk (.MCLK(MCLK), .RST(RST),
   .FRAME_SELECT_N(FRAME_SELECT_N), .WORD_VALID(WORD_VALID), .WORD(WORD),
   .WORD_CTRL(WORD_CTRL), .WORD_ADDR(WORD_ADDR),
   .WORD_DATA(WORD_DATA), .FRAME_ERROR(FRAME_ERROR));
`default_nettype wire

//--- tb/tb_serial_word_write_port.sv
// Purpose: self-checking bench of the word port
// Assumes: host model drives the link pins
// Notes: a monitor counts the output pulses
`default_nettype none
module tb_serial_word_write_port;
   timeunit 1ns;
   timeprecision 1ns;
   logic MCLK = 1'b0;
   logic RST = 1'b1;
   wire logic sclk, sdi, sel_n, word_valid, frame_error;
   wire logic [15:0] word;
   wire logic [3:0] word_ctrl;
   wire logic [3:0] word_addr;
   wire logic [7:0] word_data;
   int errors = 0, n_checks = 0, nv = 0, ne = 0;
   always #20 MCLK = ~MCLK;
   // count on the falling edge, where the registered pulses have settled
   always @(negedge MCLK) begin
      nv += (word_valid === 1'b1);
      ne += (frame_error === 1'b1);
   end
   serial_host_model i_serial_host_model (.sclk(sclk), .sdi(sdi), .sel_n(sel_n));
   serial_word_write_port i_serial_word_write_port (.MCLK(MCLK), .RST(RST), .SCLK(sclk),
      .SERIAL_DATA_IN(sdi), .FRAME_SELECT_N(sel_n), .WORD_VALID(word_valid), .WORD(word),
      .WORD_CTRL(word_ctrl), .WORD_ADDR(word_addr), .WORD_DATA(word_data),
      .FRAME_ERROR(frame_error));
   task chk(input logic [15:0] got, input logic [15:0] exp);
      n_checks++;
      if (got !== exp) begin
         errors++;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task close_out;
      $display("errors=%0d checks=%0d", errors, n_checks);
      if (errors == 0 && n_checks > 0) begin
         $display("Simulation passed");
      end else begin
         $display("Simulation failed");
      end
      $finish;
   endtask
   task t_word(input logic [15:0] w, input bit split);
      int v0;
      int e0;
      v0 = nv;
      e0 = ne;
      i_serial_host_model.send(w, 16, split);
      repeat (4) @(posedge MCLK);
      #1;
      chk(16'(nv - v0), 16'h0001);
      chk(16'(ne - e0), 16'h0000);
      chk(word, w);
      chk(16'(word_ctrl), 16'(w[15:12]));
      chk(16'(word_addr), 16'(w[11:8]));
      chk(16'(word_data), 16'(w[7:0]));
   endtask
   // cut frames must leave the held word alone
   task t_short(input int n);
      int e0;
      int v0;
      logic [15:0] w0;
      e0 = ne;
      v0 = nv;
      w0 = word;
      i_serial_host_model.send(~w0, n, 1'b0);
      repeat (8) @(posedge MCLK);
      #1;
      chk(16'(ne - e0), 16'h0001);
      chk(16'(nv - v0), 16'h0000);
      chk(word, w0);
   endtask
   initial begin
      repeat (4) @(posedge MCLK);
      #1 RST = 1'b0;
      t_word(16'hA5C3, 1'b0);
      t_word(16'h5A3C, 1'b1);
      t_short(15);
      t_short(1);
      t_word(16'hFFFF, 1'b0);
      close_out;
   end
endmodule
`default_nettype wire
